// ==== design/usd_pkg.sv ====
// Purpose: Shared constants and types for the UART status and divisor block.
// Assumes: APB register bus, word addressed, one register per 32-bit word.
// Notes: Register index times four gives the byte address.
package usd_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [3:0] USD_IDX_DIV_LO = 4'h0;
    localparam logic [3:0] USD_IDX_DIV_HI = 4'h1;
    localparam logic [3:0] USD_IDX_LINE_CTRL = 4'h3;
    localparam logic [3:0] USD_IDX_MODEM_CTRL = 4'h4;
    localparam logic [3:0] USD_IDX_LINE_STATUS = 4'h5;
    localparam logic [3:0] USD_IDX_MODEM_STATUS = 4'h6;
    localparam logic [3:0] USD_IDX_IRQ_STATUS = 4'h8;
    localparam logic [3:0] USD_IDX_IRQ_MASK = 4'h9;

    // Address layout of the word index inside paddr.
    localparam int USD_IDX_LSB = 2;
    localparam int USD_IDX_MSB = 5;

    // Reset values.
    localparam logic [7:0] USD_RST_BYTE = 8'h00;
    localparam logic [3:0] USD_RST_IRQ = 4'h0;

    // Line control fields.
    localparam int USD_LC_LEN_LSB = 0;
    localparam int USD_LC_PAR_EN = 3;
    localparam int USD_LC_PAR_EVEN = 4;
    localparam int USD_LC_PAR_STICK = 5;
    localparam int USD_LC_DIV_SEL = 7;

    // Modem control fields.
    localparam int USD_MC_DTR = 0;
    localparam int USD_MC_RTS = 1;
    localparam int USD_MC_OUT_A = 2;
    localparam int USD_MC_OUT_B = 3;
    localparam int USD_MC_LOOP = 4;

    // Interrupt status bit positions.
    localparam int USD_IRQ_RX_ERR = 0;
    localparam int USD_IRQ_OVERRUN = 1;
    localparam int USD_IRQ_MODEM = 2;
    localparam int USD_IRQ_TX_IDLE = 3;

    // Last count of the baud generator oversampling counter (factor sixteen).
    localparam logic [3:0] USD_OVERSAMPLE_LAST = 4'hF;

    // Received character as sampled by the receive shift register.
    typedef struct packed {
        logic [7:0] data;
        logic parity_bit;
        logic stop_bit;
    } usd_rx_char_t;

    // Modem input pins, all active low.
    typedef struct packed {
        logic dcd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } usd_modem_in_t;

    // Line status layout, bit 7 down to bit 0.
    typedef struct packed {
        logic err_summary;
        logic all_tx_idle;
        logic tx_fifo_empty;
        logic break_detected;
        logic framing_error;
        logic parity_error;
        logic overrun_flag;
        logic rx_data_ready;
    } usd_line_status_t;

    // Modem status layout, bit 7 down to bit 0.
    typedef struct packed {
        logic carrier_detect_level;
        logic ring_level;
        logic set_ready_level;
        logic clear_to_send_level;
        logic carrier_changed;
        logic ring_rise_flag;
        logic set_ready_changed;
        logic clear_send_changed;
    } usd_modem_status_t;

    // Whole state of the block.
    typedef struct packed {
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0] line_ctrl;
        logic [7:0] modem_ctrl;
        logic [7:0] int_enable;
        usd_line_status_t line_status;
        usd_modem_status_t modem_status;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic irq;
        logic [15:0] div_cnt;
        logic [3:0] os_cnt;
        logic tick_16x;
        logic baud_tick;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] snap;
        logic tx_push;
        logic [7:0] tx_data;
        logic rx_pop;
        logic txd;
        logic rx_shift_in;
    } usd_state_t;

endpackage : usd_pkg

// ==== design/usd_status_divisor.sv ====
// Purpose: Line status, modem status and baud divisor of a UART, on APB.
// Assumes: One clock; receiver and FIFOs sit outside and feed status in.
// Notes: Registers answer with no wait state; prdata is a flop.
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
module usd_status_divisor
    import usd_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave.
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transmit side of the UART.
    input wire logic tx_fifo_empty_in,
    input wire logic tx_shift_empty_in,
    input wire logic tx_shift_out,
    output logic tx_push,
    output logic [7:0] tx_data,
    // Receive side of the UART.
    input wire logic rx_fifo_nonempty,
    input wire logic rx_fifo_full,
    input wire logic [7:0] rx_fifo_data,
    input wire logic rx_char_valid,
    input wire usd_rx_char_t rx_char,
    output logic rx_pop,
    output logic rx_shift_in,
    // Serial pins.
    input wire logic rxd,
    output logic txd,
    input wire usd_modem_in_t modem_in,
    // Control to the rest of the UART.
    output logic [7:0] modem_ctrl,
    output logic [7:0] line_ctrl,
    output logic [7:0] int_enable,
    output logic tick_16x,
    output logic baud_tick,
    output logic irq
);

    usd_state_t st_reg;
    usd_state_t st_next;

    // Bus decode terms.
    logic [3:0] idx;
    logic setup;
    logic acc;
    logic mapped;
    logic div_sel;
    logic loop_en;
    // Receive character checks.
    logic [7:0] len_mask;
    logic [7:0] data_m;
    logic par_exp;
    logic par_err;
    logic frm_err;
    logic brk;
    logic [3:0] lvl;
    logic [3:0] lvl_old;
    logic [7:0] rd_val;
    logic [3:0] irq_set;
    logic [15:0] div_last;

    assign idx = paddr[USD_IDX_MSB:USD_IDX_LSB];
    assign setup = psel & ~penable;
    assign acc = psel & penable & st_reg.pready;
    assign div_sel = st_reg.line_ctrl[USD_LC_DIV_SEL];
    assign loop_en = st_reg.modem_ctrl[USD_MC_LOOP];
    assign div_last = {st_reg.div_hi, st_reg.div_lo} - 16'h0001;

    // Decode of mapped word addresses; other addresses answer with pslverr.
    always_comb begin
        mapped = 1'b0;
        if (paddr[USD_IDX_LSB-1:0] == '0 && paddr[7:USD_IDX_MSB+1] == '0) begin
            case (idx)
                USD_IDX_DIV_LO, USD_IDX_DIV_HI, USD_IDX_LINE_CTRL,
                USD_IDX_MODEM_CTRL, USD_IDX_LINE_STATUS, USD_IDX_MODEM_STATUS,
                USD_IDX_IRQ_STATUS, USD_IDX_IRQ_MASK: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    end

    // Character length mask and parity expectation from line control.
    always_comb begin
        case (st_reg.line_ctrl[USD_LC_LEN_LSB +: 2])
            2'h0: len_mask = 8'h1F;
            2'h1: len_mask = 8'h3F;
            2'h2: len_mask = 8'h7F;
            default: len_mask = 8'hFF;
        endcase
        data_m = rx_char.data & len_mask;
        if (st_reg.line_ctrl[USD_LC_PAR_STICK]) begin
            par_exp = ~st_reg.line_ctrl[USD_LC_PAR_EVEN];
        end else if (st_reg.line_ctrl[USD_LC_PAR_EVEN]) begin
            par_exp = ^data_m;
        end else begin
            par_exp = ~(^data_m);
        end
    end

    assign par_err = st_reg.line_ctrl[USD_LC_PAR_EN] &
                     (rx_char.parity_bit != par_exp);
    assign frm_err = ~rx_char.stop_bit;
    assign brk = (data_m == 8'h00) & ~rx_char.stop_bit &
                 (~st_reg.line_ctrl[USD_LC_PAR_EN] | ~rx_char.parity_bit);

    // level source, loopback or inverted pins.
    always_comb begin
        if (loop_en) begin
            lvl = {st_reg.modem_ctrl[USD_MC_OUT_B],
                   st_reg.modem_ctrl[USD_MC_OUT_A],
                   st_reg.modem_ctrl[USD_MC_DTR],
                   st_reg.modem_ctrl[USD_MC_RTS]};
        end else begin
            lvl = ~{modem_in.dcd_n, modem_in.ri_n,
                    modem_in.dsr_n, modem_in.cts_n};
        end
        lvl_old = {st_reg.modem_status.carrier_detect_level, st_reg.modem_status.ring_level,
                   st_reg.modem_status.set_ready_level, st_reg.modem_status.clear_to_send_level};
    end

    // Read data mux, sampled in the setup cycle.
    always_comb begin
        case (idx)
            USD_IDX_DIV_LO: rd_val = div_sel ? st_reg.div_lo : rx_fifo_data;
            USD_IDX_DIV_HI: rd_val = div_sel ? st_reg.div_hi :
                                     st_reg.int_enable;
            USD_IDX_LINE_CTRL: rd_val = st_reg.line_ctrl;
            USD_IDX_MODEM_CTRL: rd_val = st_reg.modem_ctrl;
            USD_IDX_LINE_STATUS: rd_val = st_reg.line_status;
            USD_IDX_MODEM_STATUS: rd_val = st_reg.modem_status;
            USD_IDX_IRQ_STATUS: rd_val = {4'h0, st_reg.irq_status};
            USD_IDX_IRQ_MASK: rd_val = {4'h0, st_reg.irq_mask};
            default: rd_val = 8'h00;
        endcase
        if (!mapped) begin
            rd_val = 8'h00;
        end
    end

    // Next state of the whole block.
    always_comb begin
        st_next = st_reg;
        st_next.tx_push = 1'b0;
        st_next.rx_pop = 1'b0;
        st_next.tick_16x = 1'b0;
        st_next.baud_tick = 1'b0;
        irq_set = 4'h0;

        // Bus: answer one cycle after setup, with data taken at setup.
        st_next.pready = setup;
        if (setup) begin
            st_next.prdata = {24'h000000, rd_val};
            st_next.pslverr = ~mapped;
            st_next.snap = rd_val;
        end

        // Register writes at the access edge.
        if (acc && pwrite && mapped) begin
            case (idx)
                USD_IDX_DIV_LO: begin
                    if (div_sel) begin
                        st_next.div_lo = pwdata[7:0];
                    end else begin
                        st_next.tx_push = 1'b1;
                        st_next.tx_data = pwdata[7:0];
                    end
                end
                USD_IDX_DIV_HI: begin
                    if (div_sel) begin
                        st_next.div_hi = pwdata[7:0];
                    end else begin
                        st_next.int_enable = pwdata[7:0];
                    end
                end
                USD_IDX_LINE_CTRL: st_next.line_ctrl = pwdata[7:0];
                USD_IDX_MODEM_CTRL: st_next.modem_ctrl = pwdata[7:0];
                USD_IDX_IRQ_STATUS: begin
                    st_next.irq_status = st_reg.irq_status & ~pwdata[3:0];
                end
                USD_IDX_IRQ_MASK: st_next.irq_mask = pwdata[3:0];
                default: st_next.div_lo = st_reg.div_lo;
            endcase
        end

        // Read side effects; only bits that were returned are cleared.
        if (acc && !pwrite && mapped) begin
            case (idx)
                USD_IDX_DIV_LO: st_next.rx_pop = ~div_sel;
                USD_IDX_LINE_STATUS: begin
                    st_next.line_status.break_detected =
                        st_reg.line_status.break_detected & ~st_reg.snap[4];
                    st_next.line_status.framing_error =
                        st_reg.line_status.framing_error & ~st_reg.snap[3];
                    st_next.line_status.parity_error =
                        st_reg.line_status.parity_error & ~st_reg.snap[2];
                    st_next.line_status.overrun_flag =
                        st_reg.line_status.overrun_flag & ~st_reg.snap[1];
                end
                USD_IDX_MODEM_STATUS: begin
                    st_next.modem_status.carrier_changed =
                        st_reg.modem_status.carrier_changed & ~st_reg.snap[3];
                    st_next.modem_status.ring_rise_flag =
                        st_reg.modem_status.ring_rise_flag & ~st_reg.snap[2];
                    st_next.modem_status.set_ready_changed =
                        st_reg.modem_status.set_ready_changed & ~st_reg.snap[1];
                    st_next.modem_status.clear_send_changed =
                        st_reg.modem_status.clear_send_changed & ~st_reg.snap[0];
                end
                default: st_next.rx_pop = 1'b0;
            endcase
        end

        // Receive events set flags after any clear, so a set wins.
        if (rx_char_valid) begin
            if (brk) begin
                st_next.line_status.break_detected = 1'b1;
            end
            if (frm_err) begin
                st_next.line_status.framing_error = 1'b1;
            end
            if (par_err) begin
                st_next.line_status.parity_error = 1'b1;
            end
            if (rx_fifo_full) begin
                st_next.line_status.overrun_flag = 1'b1;
                irq_set[USD_IRQ_OVERRUN] = 1'b1;
            end
            irq_set[USD_IRQ_RX_ERR] = brk | frm_err | par_err;
        end
        st_next.line_status.err_summary = st_next.line_status.break_detected |
                                  st_next.line_status.framing_error |
                                  st_next.line_status.parity_error;
        st_next.line_status.rx_data_ready = rx_fifo_nonempty;
        st_next.line_status.tx_fifo_empty = tx_fifo_empty_in & ~st_next.tx_push;
        st_next.line_status.all_tx_idle = tx_fifo_empty_in & tx_shift_empty_in &
                                  ~st_next.tx_push;
        irq_set[USD_IRQ_TX_IDLE] = st_next.line_status.all_tx_idle &
                                   ~st_reg.line_status.all_tx_idle;

        // Modem levels and change flags.
        st_next.modem_status.carrier_detect_level = lvl[3];
        st_next.modem_status.ring_level = lvl[2];
        st_next.modem_status.set_ready_level = lvl[1];
        st_next.modem_status.clear_to_send_level = lvl[0];
        if (lvl[3] != lvl_old[3]) begin
            st_next.modem_status.carrier_changed = 1'b1;
        end
        if (lvl[1] != lvl_old[1]) begin
            st_next.modem_status.set_ready_changed = 1'b1;
        end
        if (lvl[0] != lvl_old[0]) begin
            st_next.modem_status.clear_send_changed = 1'b1;
        end
        if (lvl[2] && !lvl_old[2]) begin
            st_next.modem_status.ring_rise_flag = 1'b1;
        end
        irq_set[USD_IRQ_MODEM] = (lvl[3] != lvl_old[3]) |
                                 (lvl[2] & ~lvl_old[2]) |
                                 (lvl[1] != lvl_old[1]) |
                                 (lvl[0] != lvl_old[0]);

        // Sticky interrupt status; a new event beats a write-one clear.
        st_next.irq_status = st_next.irq_status | irq_set;
        st_next.irq = |(st_next.irq_status & st_next.irq_mask);

        // divide by divisor, then by sixteen; zero stops ticks.
        if ({st_reg.div_hi, st_reg.div_lo} == 16'h0000) begin
            st_next.div_cnt = 16'h0000;
            st_next.os_cnt = 4'h0;
        end else if (st_reg.div_cnt >= div_last) begin
            st_next.div_cnt = 16'h0000;
            st_next.tick_16x = 1'b1;
            st_next.os_cnt = st_reg.os_cnt + 4'h1;
            st_next.baud_tick = (st_reg.os_cnt == USD_OVERSAMPLE_LAST);
        end else begin
            st_next.div_cnt = st_reg.div_cnt + 16'h0001;
        end

        // loopback routing of the serial path.
        st_next.txd = loop_en ? 1'b1 : tx_shift_out;
        st_next.rx_shift_in = loop_en ? tx_shift_out : rxd;
    end

    // State register; everything resets to zero except the idle serial line.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.div_lo <= USD_RST_BYTE;
            st_reg.div_hi <= USD_RST_BYTE;
            st_reg.irq_mask <= USD_RST_IRQ;
            st_reg.txd <= 1'b1;
            st_reg.rx_shift_in <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops.
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign tx_push = st_reg.tx_push;
    assign tx_data = st_reg.tx_data;
    assign rx_pop = st_reg.rx_pop;
    assign rx_shift_in = st_reg.rx_shift_in;
    assign txd = st_reg.txd;
    assign modem_ctrl = st_reg.modem_ctrl;
    assign line_ctrl = st_reg.line_ctrl;
    assign int_enable = st_reg.int_enable;
    assign tick_16x = st_reg.tick_16x;
    assign baud_tick = st_reg.baud_tick;
    assign irq = st_reg.irq;

endmodule : usd_status_divisor

// ==== tb/usd_checker_assertions.sv ====
// Purpose: Port-level checks of the UART status and divisor block.
// Assumes: Bound to the top module; one clock domain.
// Notes: Status register contents are judged by the bench.
`timescale 1ns/100ps
module usd_checker
    import usd_pkg::*;
(
    // Clock, reset and APB.
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // UART side.
    input wire logic tx_shift_out,
    input wire logic tx_push,
    input wire logic [7:0] tx_data,
    input wire logic rx_pop,
    input wire logic rx_shift_in,
    input wire logic rxd,
    input wire logic txd,
    input wire logic [7:0] modem_ctrl,
    input wire logic [7:0] line_ctrl
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic setup;
    logic acc;
    logic dat;
    logic loop;
    logic [3:0] idx;
    logic [7:0] wb;
    // Decode of the transfer in flight.
    assign setup = psel && !penable;
    assign acc = psel && penable && pready;
    assign idx = paddr[5:2];
    assign wb = pwdata[7:0];
    assign dat = idx == USD_IDX_DIV_LO && !line_ctrl[USD_LC_DIV_SEL];
    assign loop = modem_ctrl[USD_MC_LOOP];

    ready_one_a: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    ready_setup_a: assert property (setup |=> pready)
        else $error("no pready after setup");
    ready_cause_a: assert property (pready |-> $past(setup))
        else $error("pready without setup");
    unmapped_err_a: assert property (setup && (idx == 4'h2 || idx == 4'h7
        || idx > 4'h9) |=> pready && pslverr)
        else $error("unmapped access not refused");
    push_data_a: assert property (acc && pwrite && dat
        |=> tx_push && tx_data == $past(wb))
        else $error("data write gave no push");
    push_cause_a: assert property (tx_push |-> $past(acc) && $past(pwrite))
        else $error("push without write");
    div_no_push_a: assert property (acc && pwrite && idx == 4'h0
        && line_ctrl[USD_LC_DIV_SEL] |=> !tx_push)
        else $error("divisor write pushed data");
    pop_read_a: assert property (acc && !pwrite && dat |=> rx_pop)
        else $error("data read gave no pop");
    line_ctrl_a: assert property (acc && pwrite && idx == USD_IDX_LINE_CTRL
        |=> line_ctrl == $past(wb))
        else $error("line control not written");
    loop_txd_a: assert property (loop && $past(loop) |-> txd)
        else $error("serial out low in loopback");
    loop_feed_a: assert property (loop && $past(loop)
        |-> rx_shift_in == $past(tx_shift_out))
        else $error("loopback does not feed receiver");
    line_feed_a: assert property (!loop && !$past(loop)
        |-> rx_shift_in == $past(rxd))
        else $error("receiver not fed from line");
endmodule : usd_checker

bind usd_status_divisor usd_checker u_chk (.ref_clk, .rst_n, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .tx_shift_out,
    .tx_push, .tx_data, .rx_pop, .rx_shift_in, .rxd, .txd, .modem_ctrl,
    .line_ctrl);

// ==== tb/usd_peer.sv ====
// Purpose: Serial peer that drives the modem pins and the receive line.
// Assumes: Modem pins are active low; the line idles high.
// Notes: In slow mode pin changes land only every other cycle.
`timescale 1ns/100ps
module usd_peer
    import usd_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Wished levels and pacing from the bench.
    input wire logic [3:0] level,
    input wire logic slow,
    input wire logic line_bit,
    // Pins toward the block.
    output usd_modem_in_t modem_in,
    output logic rxd
);
    logic phase;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            modem_in <= 4'hF;
            rxd <= 1'b1;
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
            rxd <= line_bit;
            if (!slow || phase) begin
                modem_in <= ~level;
            end
        end
    end
endmodule : usd_peer

// ==== tb/usd_status_divisor_tb.sv ====
// Purpose: Self-checking bench of the UART status and divisor block.
// Assumes: APB master tasks; the bench acts as the FIFOs.
// Notes: Random stimulus from a fixed seed.
`timescale 1ns/100ps
module usd_status_divisor_tb
    import usd_pkg::*;
;
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, rxd;
    logic tx_fifo_empty_in, tx_shift_empty_in, tx_shift_out, tx_push, rx_pop;
    logic rx_fifo_nonempty, rx_fifo_full, rx_char_valid, rx_shift_in, txd;
    logic tick_16x, baud_tick, slow, line_bit, last_err, even, full, stk;
    logic [1:0] len;
    logic [7:0] paddr, rx_fifo_data, tx_data, modem_ctrl, line_ctrl, ie;
    logic [7:0] q, d, e, n16, nb;
    logic [31:0] pwdata, prdata;
    logic [3:0] level, lv, prev, m;
    usd_rx_char_t rx_char, c;
    usd_modem_in_t modem_in;
    int error_cnt, total_checks;

    usd_status_divisor DUT (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_fifo_empty_in(tx_fifo_empty_in),
        .tx_shift_empty_in(tx_shift_empty_in),
        .tx_shift_out(tx_shift_out), .tx_push(tx_push), .tx_data(tx_data),
        .rx_fifo_nonempty(rx_fifo_nonempty), .rx_fifo_full(rx_fifo_full),
        .rx_fifo_data(rx_fifo_data), .rx_char_valid(rx_char_valid),
        .rx_char(rx_char), .rx_pop(rx_pop), .rx_shift_in(rx_shift_in),
        .rxd(rxd), .txd(txd), .modem_in(modem_in), .modem_ctrl(modem_ctrl),
        .line_ctrl(line_ctrl), .int_enable(ie), .tick_16x(tick_16x),
        .baud_tick(baud_tick), .irq(irq));
    usd_peer u_peer (.ref_clk(ref_clk), .rst_n(rst_n), .level(level),
        .slow(slow), .line_bit(line_bit), .modem_in(modem_in), .rxd(rxd));

    // Clock at 20 MHz.
    always #25 ref_clk = ~ref_clk;
    // Random serial traffic on the line and the transmit shifter.
    always @(posedge ref_clk) begin
        {line_bit, tx_shift_out} <= 2'($urandom);
    end
    // Cuts a hung run short.
    initial begin
        repeat (60000) @(posedge ref_clk);
        error_cnt++;
        print_verdict();
    end

    // Compares one value and counts it.
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Prints the verdict and ends the run.
    task automatic print_verdict();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    // One APB transfer; holds the request until pready is sampled high.
    task automatic apb(input logic w, input logic [3:0] idx,
        input logic [7:0] wd);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                error_cnt++;
                print_verdict();
            end
            @(posedge ref_clk);
        end
        q = prdata[7:0];
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Reads a register and compares it.
    task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(q, exp);
    endtask : rd

    // Expected line status after one received character.
    function automatic logic [7:0] lsr_exp(usd_rx_char_t ch, logic ovr,
        logic ev, logic rdy, logic stk, logic [1:0] len);
        logic pe, fe, bi;
        logic [7:0] dm;
        dm = ch.data & (8'hFF >> (2'h3 - len));
        pe = stk ? (ch.parity_bit == ev) : (^{dm, ch.parity_bit}) ^ !ev;
        fe = !ch.stop_bit;
        bi = {dm, ch.parity_bit, ch.stop_bit} == 10'h000;
        return {bi | fe | pe, 2'b11, bi, fe, pe, ovr, rdy};
    endfunction : lsr_exp

    initial begin
        {ref_clk, rst_n, psel, penable, pwrite, rx_char_valid} = 6'h00;
        {rx_fifo_nonempty, rx_fifo_full, slow, line_bit, tx_shift_out} = 5'h00;
        {tx_fifo_empty_in, tx_shift_empty_in} = 2'b11;
        {paddr, rx_fifo_data, pwdata, level, rx_char} = '0;
        {error_cnt, total_checks} = 0;
        void'($urandom(29067));
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(1'b1, USD_IDX_LINE_CTRL, 8'h83);
        rd(USD_IDX_DIV_LO, 8'h00);
        rd(USD_IDX_DIV_HI, 8'h00);
        repeat (4) begin
            {d, e} = 16'($urandom);
            apb(1'b1, USD_IDX_DIV_LO, d);
            apb(1'b1, USD_IDX_DIV_HI, e);
            rd(USD_IDX_DIV_LO, d);
            rd(USD_IDX_DIV_HI, e);
        end
        apb(1'b1, USD_IDX_DIV_LO, 8'h03);
        apb(1'b1, USD_IDX_DIV_HI, 8'h00);
        repeat (100) @(posedge ref_clk);
        {n16, nb} = 16'h0000;
        repeat (192) begin
            @(negedge ref_clk);
            n16 += {7'h00, tick_16x};
            nb += {7'h00, baud_tick};
        end
        check(n16, 8'h40);
        check(nb, 8'h04);
        apb(1'b1, USD_IDX_LINE_CTRL, 8'h1B);
        rd(USD_IDX_LINE_STATUS, 8'h60);
        rd(USD_IDX_MODEM_STATUS, 8'h00);
        // A written character leaves both FIFO and shifter busy.
        apb(1'b1, USD_IDX_DIV_LO, 8'($urandom));
        {tx_fifo_empty_in, tx_shift_empty_in} <= 2'b00;
        rd(USD_IDX_LINE_STATUS, 8'h00);
        tx_fifo_empty_in <= 1'b1;
        rd(USD_IDX_LINE_STATUS, 8'h20);
        tx_shift_empty_in <= 1'b1;
        rd(USD_IDX_LINE_STATUS, 8'h60);
        // Received characters, the first one a break.
        for (int i = 0; i < 10; i++) begin
            c = (i == 0) ? 10'h000 : 10'($urandom);
            {len, stk, even, full} = 5'($urandom);
            rx_fifo_nonempty <= 1'($urandom);
            rx_fifo_full <= full;
            apb(1'b1, USD_IDX_LINE_CTRL, {2'b00, stk, even, 2'b10, len});
            rx_char <= c;
            rx_char_valid <= 1'b1;
            @(posedge ref_clk);
            rx_char_valid <= 1'b0;
            e = lsr_exp(c, full, even, rx_fifo_nonempty, stk, len);
            rd(USD_IDX_LINE_STATUS, e);
            rd(USD_IDX_LINE_STATUS, e & 8'h61);
        end
        d = 8'($urandom);
        rx_fifo_data <= d;
        rd(USD_IDX_DIV_LO, d);
        apb(1'b1, USD_IDX_DIV_HI, ~d);
        rd(USD_IDX_DIV_HI, ~d);
        check(ie, ~d);
        // Modem pin changes with the modem interrupt unmasked.
        apb(1'b1, USD_IDX_IRQ_STATUS, 8'h0F);
        apb(1'b1, USD_IDX_IRQ_MASK, 8'h04);
        prev = 4'h0;
        repeat (8) begin
            lv = 4'($urandom);
            level <= lv;
            slow <= 1'($urandom);
            repeat (4) @(posedge ref_clk);
            e = {lv, lv[3] ^ prev[3], lv[2] & !prev[2], lv[1:0] ^ prev[1:0]};
            if (e[3:0] != 4'h0) begin
                check({7'h00, irq}, 8'h01);
            end
            rd(USD_IDX_MODEM_STATUS, e);
            rd(USD_IDX_MODEM_STATUS, {lv, 4'h0});
            apb(1'b1, USD_IDX_IRQ_STATUS, 8'h04);
            repeat (2) @(posedge ref_clk);
            check({7'h00, irq}, 8'h00);
            prev = lv;
        end
        // A masked event sets status but not the output.
        apb(1'b1, USD_IDX_IRQ_MASK, 8'h00);
        level <= ~prev;
        repeat (4) @(posedge ref_clk);
        check({7'h00, irq}, 8'h00);
        rd(USD_IDX_IRQ_STATUS, 8'h04);
        // Loopback mirrors the control bits.
        repeat (4) begin
            m = 4'($urandom);
            apb(1'b1, USD_IDX_MODEM_CTRL, {4'h1, m});
            repeat (20) @(posedge ref_clk);
            apb(1'b0, USD_IDX_MODEM_STATUS, 8'h00);
            check(q & 8'hF0, {m[3], m[2], m[0], m[1], 4'h0});
        end
        apb(1'b1, USD_IDX_MODEM_CTRL, 8'h00);
        rd(4'h7, 8'h00);
        check({7'h00, last_err}, 8'h01);
        print_verdict();
    end
endmodule : usd_status_divisor_tb
